// >>> tcc_defs.svh
// register offsets, field positions and codes of the timer compare block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_OFF_CMP    8'h23
`define TCC_OFF_CNT    8'h24
`define TCC_OFF_CTL    8'h25
`define TCC_OFF_FLG    8'h36
`define TCC_OFF_MSK    8'h37
`define TCC_DATA_BIAS  8'h20
`define TCC_BIT_CMP    7
`define TCC_BIT_OVF    6
`define TCC_CTL_WGM0   6
`define TCC_CTL_COMHI  5
`define TCC_CTL_COMLO  4
`define TCC_CTL_WGM1   3
`define TCC_CTL_CSHI   2
`define TCC_WGM_NORMAL 2'b00
`define TCC_WGM_PC     2'b01
`define TCC_WGM_CTC    2'b10
`define TCC_WGM_FAST   2'b11
`define TCC_COM_OFF    2'b00
`define TCC_COM_TOGGLE 2'b01
`define TCC_COM_CLR    2'b10
`define TCC_COM_SET    2'b11
`define TCC_CS_STOP    3'h0
`define TCC_CS_DIV1    3'h1
`define TCC_CS_DIV8    3'h2
`define TCC_CS_DIV64   3'h3
`define TCC_CS_DIV256  3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_MASK8      10'h007
`define TCC_MASK64     10'h03f
`define TCC_MASK256    10'h0ff
`define TCC_MASK1024   10'h3ff
`define TCC_PRE_STEP   10'h001
`define TCC_CNT_MAX    8'hff
`define TCC_CNT_BOT    8'h00
`define TCC_CNT_STEP   8'h01
`define TCC_ZERO8      8'h00
`endif

// >>> tcc_pin_model.sv
// far-side model: external count pin source and the compare pin wire
`default_nettype none
module tcc_pin_model (
   input  wire logic       core_clk,    // i/o clock
   input  wire logic       pulseGo,     // start a burst of pin pulses
   input  wire logic [3:0] pulseCnt,    // falling edges in the burst
   input  wire logic       pinOut,      // value the block drives
   input  wire logic       pinOe,       // block driver enable
   output logic            extCountPin, // count pin, idles high
   output logic            busy,        // burst in progress
   output logic            pinLevel     // resolved pin wire
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] left_q = 4'h0;
   logic [1:0] ph_q   = 2'h0;
   logic       pin_q  = 1'b1;
   logic       last_q = 1'b0;
   // four cycles per level, slow enough for the two-flop synchroniser
   always @(posedge core_clk) begin
      if (left_q == 4'h0) begin
         ph_q <= 2'h0;
         if (pulseGo)
            left_q <= pulseCnt;
      end else begin
         ph_q <= ph_q + 2'h1;
         if (ph_q == 2'h3) begin
            pin_q <= ~pin_q;
            if (!pin_q)
               left_q <= left_q - 4'h1;
         end
      end
      if (pinOe)
         last_q <= pinOut;
   end
   // no pull on the wire: undriven shows the inverse of the last driven value
   assign extCountPin = pin_q;
   assign busy        = (left_q != 4'h0);
   assign pinLevel    = pinOe ? pinOut : ~last_q;
endmodule
`default_nettype wire

// >>> tcc_pkg.sv
// types of the timer compare block
`default_nettype none
package tcc_pkg;
   typedef struct packed {
      logic [1:0] wgm;
      logic [1:0] com;
      logic [2:0] cs;
   } tcc_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       ioSpace;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } tcc_bus_req_t;

   typedef struct packed {
      tcc_ctrl_t  ctrl;
      logic [7:0] cnt;
      logic [7:0] ocr;
      logic       ocf;
      logic       tov;
      logic       ocie;
      logic       toie;
      logic       oc;
      logic       dirDown;
      logic       block;
      logic [9:0] pre;
      logic [2:0] extSync;
      logic [7:0] rdata;
      logic       irqCmp;
      logic       irqOvf;
      logic       pinOut;
      logic       pinOe;
      logic       override;
   } tcc_state_t;
endpackage
`default_nettype wire

// >>> tcc_timer.sv
// 8-bit timer with compare output, prescaler, flags and i/o register port
`default_nettype none
`include "tcc_defs.svh"

// Overview of operation
// - nonzero output mode routes the compare waveform onto the pin instead of port data
// - pin driver enabled only when the port direction bit selects output
// - non-PWM codes: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM: 10 clears on match sets at bottom, 11 inverse, 01 reserved
// - fast PWM with compare equal top and upper bit set: skip match, keep bottom action
// - phase-correct: 10 clears on up match, sets on down match; 11 inverse
// - phase-correct with compare equal top and upper bit set: skip match, act at top
// - clock select 000 stops; 001..101 give divide by 1, 8, 64, 256, 1024
// - clock select 110 and 111 count falling edges of the external pin
// - external pin counts even when the pin is an output
// - software reads and writes the 8-bit counter directly
// - a counter write suppresses the compare match on the next timer tick
// - compare value is compared with the counter all the time
// - compare flag sets on a timer tick with counter equal to compare value, unless a counter write blocks that tick
// - compare flag clears when its interrupt vector runs
// - writing one clears the compare flag, zero leaves it
// - compare request needs enable, global enable and flag all set
// - overflow request needs enable, global enable and flag all set
// - registers decode at i/o offset and at offset plus 0x20 in data space
// - mode bits: normal, phase-correct, clear-on-match, fast PWM
// - overflow flag sets on overflow, clears on vector or written one
// - in phase-correct mode overflow flag sets on turning at zero
module tcc_timer (
   input  wire logic                 core_clk,        // i/o clock
   input  wire logic                 reset,           // synchronous, active high
   input  wire tcc_pkg::tcc_bus_req_t busReq,         // cpu register access
   output logic [7:0]                rdData,          // read data, one cycle after rd
   input  wire logic                 globalIrqEnable, // cpu global interrupt enable
   input  wire logic                 cmpVectorAck,    // compare vector executed
   input  wire logic                 ovfVectorAck,    // overflow vector executed
   output logic                      irqCmp,          // compare interrupt request
   output logic                      irqOvf,          // overflow interrupt request
   input  wire logic                 extCountPin,     // external count pin, async
   input  wire logic                 portValue,       // normal port output value
   input  wire logic                 portDir,         // port direction, 1 = output
   output logic                      pinOut,          // value driven to the pin
   output logic                      pinOe,           // pin driver enable
   output logic                      cmpOverride      // compare output owns the pin
);
   // ****************************************
   // helpers
   // ****************************************
   // hit at i/o offset or at the data-space alias
   function automatic logic regHit(input tcc_pkg::tcc_bus_req_t r, input logic [7:0] off);
      regHit = r.ioSpace ? (r.addr == off) : (r.addr == off + `TCC_DATA_BIAS);
   endfunction

   // timer tick from the selected source
   function automatic logic srcTick(input logic [2:0] cs, input logic [9:0] pre,
                                    input logic fall);
      unique case (cs)
         `TCC_CS_STOP:    srcTick = 1'b0;
         `TCC_CS_DIV1:    srcTick = 1'b1;
         `TCC_CS_DIV8:    srcTick = (pre & `TCC_MASK8) == `TCC_MASK8;
         `TCC_CS_DIV64:   srcTick = (pre & `TCC_MASK64) == `TCC_MASK64;
         `TCC_CS_DIV256:  srcTick = (pre & `TCC_MASK256) == `TCC_MASK256;
         `TCC_CS_DIV1024: srcTick = (pre & `TCC_MASK1024) == `TCC_MASK1024;
         default:         srcTick = fall;
      endcase
   endfunction

   // ****************************************
   // state
   // ****************************************
   tcc_pkg::tcc_state_t s_q;
   tcc_pkg::tcc_state_t s_d;
   logic                extFall;
   logic                tick;
   logic                eq;
   logic                match;
   logic                hitCmp;
   logic                hitCnt;
   logic                hitCtl;
   logic                hitFlg;
   logic                hitMsk;
   logic                wrCnt;
   logic                wrFlg;

   // pin direction plays no part: the edge counts even when it is an output
   assign extFall = s_q.extSync[2] & ~s_q.extSync[1];
   assign tick    = srcTick(s_q.ctrl.cs, s_q.pre, extFall);
   assign eq      = s_q.cnt == s_q.ocr;
   assign match   = tick & eq & ~s_q.block;
   assign hitCmp  = regHit(busReq, `TCC_OFF_CMP);
   assign hitCnt  = regHit(busReq, `TCC_OFF_CNT);
   assign hitCtl  = regHit(busReq, `TCC_OFF_CTL);
   assign hitFlg  = regHit(busReq, `TCC_OFF_FLG);
   assign hitMsk  = regHit(busReq, `TCC_OFF_MSK);
   assign wrCnt   = busReq.wr & hitCnt;
   assign wrFlg   = busReq.wr & hitFlg;

   // ****************************************
   // next state
   // ****************************************
   // counting, waveform, flags and register port in one pass
   always_comb begin
      logic cmpEv;
      logic ovfEv;
      logic atMax;
      logic [1:0] com;
      cmpEv = 1'b0;
      ovfEv = 1'b0;
      atMax = s_q.cnt == `TCC_CNT_MAX;
      com   = s_q.ctrl.com;
      s_d   = s_q;
      s_d.pre     = s_q.pre + `TCC_PRE_STEP;
      s_d.extSync = {s_q.extSync[1:0], extCountPin};
      s_d.rdata   = `TCC_ZERO8;
      // counter sequence per waveform mode
      if (tick) begin
         s_d.block = 1'b0;
         cmpEv     = match;
         unique case (s_q.ctrl.wgm)
            `TCC_WGM_NORMAL: begin
               s_d.cnt = s_q.cnt + `TCC_CNT_STEP;
               ovfEv   = atMax;
            end
            `TCC_WGM_CTC: begin
               s_d.cnt = eq ? `TCC_CNT_BOT : s_q.cnt + `TCC_CNT_STEP;
               ovfEv   = atMax & ~eq;
            end
            `TCC_WGM_FAST: begin
               s_d.cnt = s_q.cnt + `TCC_CNT_STEP;
               ovfEv   = atMax;
            end
            `TCC_WGM_PC: begin
               // the count turns at max and zero without holding there: the same tick already steps one back
               if (!s_q.dirDown) begin
                  if (atMax) begin
                     s_d.dirDown = 1'b1;
                     s_d.cnt     = s_q.cnt - `TCC_CNT_STEP;
                  end else begin
                     s_d.cnt     = s_q.cnt + `TCC_CNT_STEP;
                  end
               end else begin
                  if (s_q.cnt == `TCC_CNT_BOT) begin
                     s_d.dirDown = 1'b0;
                     s_d.cnt     = s_q.cnt + `TCC_CNT_STEP;
                     ovfEv       = 1'b1;
                  end else begin
                     s_d.cnt     = s_q.cnt - `TCC_CNT_STEP;
                  end
               end
            end
         endcase
         // compare output unit
         unique case (s_q.ctrl.wgm)
            `TCC_WGM_NORMAL, `TCC_WGM_CTC: begin
               if (match) begin
                  unique case (com)
                     `TCC_COM_OFF:    s_d.oc = s_q.oc;
                     `TCC_COM_TOGGLE: s_d.oc = ~s_q.oc;
                     `TCC_COM_CLR:    s_d.oc = 1'b0;
                     `TCC_COM_SET:    s_d.oc = 1'b1;
                  endcase
               end
            end
            `TCC_WGM_FAST: begin
               // code 01 is reserved and leaves the output alone
               if (com[1]) begin
                  if (match && s_q.ocr != `TCC_CNT_MAX) s_d.oc = com[0];
                  if (atMax) s_d.oc = ~com[0];
               end
            end
            `TCC_WGM_PC: begin
               if (com[1]) begin
                  if (match && s_q.ocr != `TCC_CNT_MAX)
                     s_d.oc = s_q.dirDown ? ~com[0] : com[0];
                  if (atMax && !s_q.dirDown && s_q.ocr == `TCC_CNT_MAX)
                     s_d.oc = ~com[0];
               end
            end
         endcase
      end
      // register writes
      if (busReq.wr) begin
         if (hitCtl) begin
            s_d.ctrl.wgm = {busReq.wdata[`TCC_CTL_WGM1], busReq.wdata[`TCC_CTL_WGM0]};
            s_d.ctrl.com = busReq.wdata[`TCC_CTL_COMHI:`TCC_CTL_COMLO];
            s_d.ctrl.cs  = busReq.wdata[`TCC_CTL_CSHI:0];
         end
         if (hitCmp) s_d.ocr = busReq.wdata;
         if (hitMsk) begin
            s_d.ocie = busReq.wdata[`TCC_BIT_CMP];
            s_d.toie = busReq.wdata[`TCC_BIT_OVF];
         end
      end
      // software write wins over the count and blocks the next match
      if (wrCnt) begin
         s_d.cnt   = busReq.wdata;
         s_d.block = 1'b1;
      end
      // flags: clear by vector or written one, a coinciding set wins
      if (cmpVectorAck || (wrFlg && busReq.wdata[`TCC_BIT_CMP])) s_d.ocf = 1'b0;
      if (ovfVectorAck || (wrFlg && busReq.wdata[`TCC_BIT_OVF])) s_d.tov = 1'b0;
      if (cmpEv) s_d.ocf = 1'b1;
      if (ovfEv) s_d.tov = 1'b1;
      // registered read data; unmapped offsets read zero
      if (busReq.rd) begin
         if (hitCmp) s_d.rdata = s_q.ocr;
         if (hitCnt) s_d.rdata = s_q.cnt;
         if (hitCtl) s_d.rdata = {1'b0, s_q.ctrl.wgm[0], s_q.ctrl.com,
                                  s_q.ctrl.wgm[1], s_q.ctrl.cs};
         if (hitFlg) s_d.rdata = {s_q.ocf, s_q.tov, 6'h00};
         if (hitMsk) s_d.rdata = {s_q.ocie, s_q.toie, 6'h00};
      end
      // requests follow the next flag and mask values
      s_d.irqCmp   = s_d.ocie & globalIrqEnable & s_d.ocf;
      s_d.irqOvf   = s_d.toie & globalIrqEnable & s_d.tov;
      s_d.override = s_d.ctrl.com != `TCC_COM_OFF;
      s_d.pinOut   = s_d.override ? s_d.oc : portValue;
      s_d.pinOe    = portDir;
   end

   // ****************************************
   // registers
   // ****************************************
   // single state register, cleared by reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign rdData      = s_q.rdata;
   assign irqCmp      = s_q.irqCmp;
   assign irqOvf      = s_q.irqOvf;
   assign pinOut      = s_q.pinOut;
   assign pinOe       = s_q.pinOe;
   assign cmpOverride = s_q.override;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_cntWrite;
      wrCnt;
   endsequence
   sequence s_blockedTick;
      tick && !wrFlg && !cmpVectorAck && !s_q.ocf;
   endsequence

   property p_override;
      s_q.override |-> pinOut == s_q.oc;
   endproperty
   a_override: assert property (p_override) else $error("pin not fed by compare output");

   property p_driver;
      pinOe |-> $past(portDir);
   endproperty
   a_driver: assert property (p_driver) else $error("driver on without output direction");

   property p_toggle;
      (match && s_q.ctrl.wgm == `TCC_WGM_NORMAL && s_q.ctrl.com == `TCC_COM_TOGGLE)
         |=> s_q.oc != $past(s_q.oc);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle on match missing");

   property p_fastBottom;
      (tick && s_q.ctrl.wgm == `TCC_WGM_FAST && s_q.ctrl.com == `TCC_COM_CLR
       && s_q.cnt == `TCC_CNT_MAX) |=> s_q.oc;
   endproperty
   a_fastBottom: assert property (p_fastBottom) else $error("fast pwm bottom set missing");

   property p_fastTop;
      (tick && s_q.ctrl.wgm == `TCC_WGM_FAST && s_q.ctrl.com == `TCC_COM_SET
       && s_q.ocr == `TCC_CNT_MAX && s_q.cnt == `TCC_CNT_MAX) |=> !s_q.oc;
   endproperty
   a_fastTop: assert property (p_fastTop) else $error("fast pwm top match not ignored");

   property p_pcUp;
      (match && s_q.ctrl.wgm == `TCC_WGM_PC && s_q.ctrl.com == `TCC_COM_CLR
       && !s_q.dirDown && s_q.ocr != `TCC_CNT_MAX) |=> !s_q.oc;
   endproperty
   a_pcUp: assert property (p_pcUp) else $error("phase correct up match wrong");

   property p_stopped;
      (s_q.ctrl.cs == `TCC_CS_STOP && !wrCnt) |=> s_q.cnt == $past(s_q.cnt);
   endproperty
   a_stopped: assert property (p_stopped) else $error("stopped counter moved");

   property p_extCount;
      (extFall && s_q.ctrl.cs[2:1] == 2'b11 && s_q.ctrl.wgm == `TCC_WGM_NORMAL && !wrCnt)
         |=> s_q.cnt == $past(s_q.cnt) + `TCC_CNT_STEP;
   endproperty
   a_extCount: assert property (p_extCount) else $error("external edge did not count");

   property p_block;
      s_cntWrite ##1 s_blockedTick |=> !s_q.ocf;
   endproperty
   a_block: assert property (p_block) else $error("match after counter write");

   property p_flagSet;
      match |=> s_q.ocf;
   endproperty
   a_flagSet: assert property (p_flagSet) else $error("compare flag not set");

   property p_flagW1c;
      (wrFlg && busReq.wdata[`TCC_BIT_CMP] && !match) |=> !s_q.ocf;
   endproperty
   a_flagW1c: assert property (p_flagW1c) else $error("write one did not clear flag");

   property p_irqCmp;
      irqCmp |-> (s_q.ocie && s_q.ocf && $past(globalIrqEnable));
   endproperty
   a_irqCmp: assert property (p_irqCmp) else $error("compare request without cause");

   property p_readCmp;
      (busReq.rd && busReq.ioSpace && busReq.addr == `TCC_OFF_CMP) |=> rdData == $past(s_q.ocr);
   endproperty
   a_readCmp: assert property (p_readCmp) else $error("compare register read wrong");

   property p_pcTop;
      (tick && s_q.ctrl.wgm == `TCC_WGM_PC && s_q.ctrl.com == `TCC_COM_CLR && !s_q.dirDown
       && s_q.cnt == `TCC_CNT_MAX && s_q.ocr == `TCC_CNT_MAX) |=> s_q.oc;
   endproperty
   a_pcTop: assert property (p_pcTop) else $error("phase correct top action missing");

   property p_vecClear;
      (cmpVectorAck && !match) |=> !s_q.ocf;
   endproperty
   a_vecClear: assert property (p_vecClear) else $error("vector did not clear flag");

   property p_irqOvf;
      irqOvf |-> (s_q.toie && s_q.tov && $past(globalIrqEnable));
   endproperty
   a_irqOvf: assert property (p_irqOvf) else $error("overflow request without cause");

   property p_ctcClear;
      (tick && s_q.ctrl.wgm == `TCC_WGM_CTC && eq && !wrCnt) |=> s_q.cnt == `TCC_CNT_BOT;
   endproperty
   a_ctcClear: assert property (p_ctcClear) else $error("counter not cleared on match");

   property p_pcBottom;
      (tick && s_q.ctrl.wgm == `TCC_WGM_PC && s_q.dirDown && s_q.cnt == `TCC_CNT_BOT)
         |=> s_q.tov;
   endproperty
   a_pcBottom: assert property (p_pcBottom) else $error("no overflow on turn at zero");
endmodule
`default_nettype wire

// >>> timer2_compare_output_control_tb_top.sv
// self-checking bench for the timer compare block
`default_nettype none
`include "tcc_defs.svh"
module timer2_compare_output_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  core_clk = 1'b0;
   logic                  reset    = 1'b1;
   tcc_pkg::tcc_bus_req_t busReq   = '0;
   logic [7:0]            rdData, junk;
   logic                  globalIrqEnable = 1'b0, cmpVectorAck = 1'b0, ovfVectorAck = 1'b0;
   logic                  portValue = 1'b0, portDir = 1'b0, pulseGo = 1'b0;
   logic                  irqCmp, irqOvf, extCountPin, pinOut, pinOe, cmpOverride;
   logic                  busy, pinLevel;
   int                    errorCnt = 0, nCompared = 0, cyc = 0;
   // mode, output code, start count, expected pin after six ticks; rows chain oc and direction
   localparam logic [12:0] OUT_TBL [13] = '{
      {2'b00, 2'b11, 8'h1e, 1'b1}, {2'b00, 2'b10, 8'h1e, 1'b0}, {2'b00, 2'b01, 8'h1e, 1'b1},
      {2'b11, 2'b10, 8'h1e, 1'b0}, {2'b11, 2'b10, 8'hfe, 1'b1}, {2'b11, 2'b11, 8'h1e, 1'b1},
      {2'b11, 2'b11, 8'hfe, 1'b0}, {2'b11, 2'b01, 8'h1e, 1'b0}, {2'b01, 2'b11, 8'h1e, 1'b1},
      {2'b01, 2'b10, 8'h1e, 1'b0}, {2'b01, 2'b10, 8'hfe, 1'b0}, {2'b01, 2'b10, 8'h22, 1'b1},
      {2'b10, 2'b01, 8'h1e, 1'b0}};
   localparam int         DIVS [5] = '{1, 8, 64, 256, 1024};
   localparam logic [7:0] REGS [5] = '{8'h23, 8'h24, 8'h25, 8'h36, 8'h37};

   // ******************************
   // clock, design and far side
   // ******************************
   always #20 core_clk = ~core_clk;
   tcc_timer uut (
      .core_clk        (core_clk),
      .reset           (reset),
      .busReq          (busReq),
      .rdData          (rdData),
      .globalIrqEnable (globalIrqEnable),
      .cmpVectorAck    (cmpVectorAck),
      .ovfVectorAck    (ovfVectorAck),
      .irqCmp          (irqCmp),
      .irqOvf          (irqOvf),
      .extCountPin     (extCountPin),
      .portValue       (portValue),
      .portDir         (portDir),
      .pinOut          (pinOut),
      .pinOe           (pinOe),
      .cmpOverride     (cmpOverride)
   );
   tcc_pin_model pins (
      .core_clk    (core_clk),
      .pulseGo     (pulseGo),
      .pulseCnt    (4'h3),
      .pinOut      (pinOut),
      .pinOe       (pinOe),
      .extCountPin (extCountPin),
      .busy        (busy),
      .pinLevel    (pinLevel)
   );

   // ******************************
   // tasks
   // ******************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // request held across one rising edge, then an idle cycle so strobes never re-fire
   task automatic acc(input logic [7:0] a, input logic io, input logic w,
                      input logic [7:0] d, output logic [7:0] seen);
      busReq = '{addr: a, ioSpace: io, wr: w, rd: ~w, wdata: d};
      @(negedge core_clk);
      seen   = rdData;
      busReq = '0;
      @(negedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(a, 1'b1, 1'b1, d, junk);
   endtask
   task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] exp);
      logic [7:0] seen;
      acc(a, io, 1'b0, 8'h00, seen);
      check(seen, exp);
   endtask
   function automatic logic [7:0] ctl(input logic [1:0] wg, input logic [1:0] cm,
                                      input logic [2:0] cs);
      return {1'b0, wg[0], cm, wg[1], cs};
   endfunction
   // load the counter, let exactly n rising edges see the clock select, then stop
   task automatic run(input logic [7:0] c0, input logic [7:0] cv, input int n);
      wr(`TCC_OFF_CNT, c0); // counter reloaded only while stopped
      wr(`TCC_OFF_CTL, cv);
      repeat (n - 2) @(negedge core_clk);
      wr(`TCC_OFF_CTL, cv & 8'hf8);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask
   task automatic tallyAndFinish();
      $display("compared %0d, mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // watchdog: the whole run needs under 9000 cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errorCnt++;
         tallyAndFinish();
      end
   end

   // ******************************
   // main sequence
   // ******************************
   initial begin
      repeat (10) @(negedge core_clk);
      reset = 1'b0;
      foreach (REGS[i]) rd(REGS[i], 1'b1, 8'h00);
      rd(8'h30, 1'b1, 8'h00);
      $display("test reset done");
      acc(`TCC_DATA_BIAS + `TCC_OFF_CMP, 1'b0, 1'b1, 8'h20, junk);
      rd(`TCC_OFF_CMP, 1'b1, 8'h20);
      wr(`TCC_OFF_CNT, 8'h5a);
      rd(`TCC_DATA_BIAS + `TCC_OFF_CNT, 1'b0, 8'h5a);
      rd(`TCC_OFF_CNT, 1'b0, 8'h00);
      repeat (8) @(negedge core_clk);
      rd(`TCC_OFF_CNT, 1'b1, 8'h5a);
      $display("test access done");
      // counter loaded equal to the compare value: first tick must not match
      run(8'h20, ctl(2'b00, 2'b00, 3'h1), 6);
      rd(`TCC_OFF_FLG, 1'b1, 8'h00);
      rd(`TCC_OFF_CNT, 1'b1, 8'h26);
      // a write to a running counter also blocks the match on the next tick
      wr(`TCC_OFF_CTL, ctl(2'b00, 2'b00, 3'h1));
      wr(`TCC_OFF_CNT, 8'h20);
      wr(`TCC_OFF_CTL, 8'h00);
      rd(`TCC_OFF_FLG, 1'b1, 8'h00);
      $display("test write blocks match done");
      portDir   = 1'b1;
      portValue = 1'b1;
      repeat (2) @(negedge core_clk);
      check({7'h0, pinLevel}, 8'h01);
      check({7'h0, cmpOverride}, 8'h00);
      portDir = 1'b0;
      repeat (2) @(negedge core_clk);
      check({7'h0, pinOe}, 8'h00);
      portDir = 1'b1;
      foreach (OUT_TBL[i]) begin
         run(OUT_TBL[i][8:1], ctl(OUT_TBL[i][12:11], OUT_TBL[i][10:9], 3'h1), 6);
         check({7'h0, pinLevel}, {7'h0, OUT_TBL[i][0]});
         check({6'h0, pinOe, cmpOverride}, 8'h03);
      end
      rd(`TCC_OFF_CNT, 1'b1, 8'h03);
      $display("test output modes done");
      rd(`TCC_OFF_FLG, 1'b1, 8'hc0);
      wr(`TCC_OFF_FLG, 8'h00);
      rd(`TCC_OFF_FLG, 1'b1, 8'hc0);
      wr(`TCC_OFF_FLG, 8'h80);
      rd(`TCC_OFF_FLG, 1'b1, 8'h40);
      wr(`TCC_OFF_FLG, 8'h40);
      rd(`TCC_OFF_FLG, 1'b1, 8'h00);
      $display("test flag clear done");
      // phase correct, compare at top: turn at zero flags overflow, top sets the output
      wr(`TCC_OFF_CMP, 8'hff);
      run(8'h01, ctl(2'b01, 2'b10, 3'h1), 6);
      rd(`TCC_OFF_FLG, 1'b1, 8'h40);
      run(8'hfe, ctl(2'b01, 2'b10, 3'h1), 6);
      check({7'h0, pinLevel}, 8'h01);
      wr(`TCC_OFF_FLG, 8'hc0);
      wr(`TCC_OFF_CMP, 8'h20);
      $display("test phase correct ends done");
      wr(`TCC_OFF_MSK, 8'hc0);
      globalIrqEnable = 1'b1;
      run(8'h1e, ctl(2'b00, 2'b00, 3'h1), 6);
      check({7'h0, irqCmp}, 8'h01);
      globalIrqEnable = 1'b0;
      repeat (2) @(negedge core_clk);
      check({7'h0, irqCmp}, 8'h00);
      globalIrqEnable = 1'b1;
      pulse(cmpVectorAck);
      check({6'h0, irqCmp, irqOvf}, 8'h00);
      run(8'hfe, ctl(2'b00, 2'b00, 3'h1), 6);
      check({6'h0, irqCmp, irqOvf}, 8'h01);
      wr(`TCC_OFF_MSK, 8'h80);
      repeat (2) @(negedge core_clk);
      check({7'h0, irqOvf}, 8'h00);
      pulse(ovfVectorAck);
      rd(`TCC_OFF_FLG, 1'b1, 8'h00);
      wr(`TCC_OFF_MSK, 8'h00);
      $display("test interrupts done");
      // five ticks expected whatever the free prescaler phase
      for (int k = 1; k <= 5; k++) begin
         run(8'h00, ctl(2'b00, 2'b00, k[2:0]), 5 * DIVS[k - 1]);
         rd(`TCC_OFF_CNT, 1'b1, 8'h05);
      end
      $display("test prescaler done");
      // pin is an output here, yet its edges still count
      for (int k = 6; k <= 7; k++) begin
         wr(`TCC_OFF_CNT, 8'h00);
         wr(`TCC_OFF_CTL, ctl(2'b00, 2'b00, k[2:0]));
         pulse(pulseGo);
         for (int w = 0; w < 100 && busy; w++) @(negedge core_clk);
         repeat (6) @(negedge core_clk);
         wr(`TCC_OFF_CTL, 8'h00);
         rd(`TCC_OFF_CNT, 1'b1, 8'h03);
      end
      $display("test external count done");
      tallyAndFinish();
   end
endmodule
`default_nettype wire
